// ---- core/tc_defines.vh ----
// Shared constants of the timer/counter core
`ifndef TC_DEFINES_VH
`define TC_DEFINES_VH
// ------------------------------------------------------------
// Counter width modes
// ------------------------------------------------------------
`define TC_MODE_W 2
`define TC_MODE_16 2'h0
`define TC_MODE_8 2'h1
`define TC_MODE_32 2'h2
// ------------------------------------------------------------
// Waveform modes
// ------------------------------------------------------------
`define TC_WAVE_FREQ 1'h0
`define TC_WAVE_PWM 1'h1
// ------------------------------------------------------------
// Prescaler select width and reset values
// ------------------------------------------------------------
`define TC_PSC_W 3
`define TC_PSC_RESET 3'h0
`define TC_COUNT_RESET 32'h00000000
// ------------------------------------------------------------
// Timing: configuration crossing, in core-clock periods of 10 ns
// ------------------------------------------------------------
`define TC_SYNC_TIME_NS 30
`define TC_CLK_PERIOD_NS 10
`define TC_SYNC_CYCLES (`TC_SYNC_TIME_NS / `TC_CLK_PERIOD_NS)
`define TC_SYNC_CNT_W 4
`endif

// ---- core/tc_prescaler.v ----
// Prescaler dividing counter clock ticks by a power of two
`timescale 1ns/100ps
`default_nettype none
`include "tc_defines.vh"
module tc_prescaler #(
   parameter DIV_W = 8
) (
   input wire clock,
   input wire rst_n,
   input wire clear,
   input wire tick_in,
   input wire [`TC_PSC_W-1:0] sel,
   output wire tick_out
);
   reg [DIV_W-1:0] div_q;
   wire [DIV_W-1:0] mask;

   assign mask = (({{(DIV_W-1){1'b0}}, 1'b1}) << sel) -
      {{(DIV_W-1){1'b0}}, 1'b1};
   assign tick_out = tick_in && ((div_q & mask) == mask);

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= {DIV_W{1'b0}};
      end else if (clear) begin
         div_q <= {DIV_W{1'b0}};
      end else if (tick_in) begin
         div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end
endmodule // tc_prescaler
`default_nettype wire

// ---- core/tc_core.v ----
// Timer/counter core: prescaler, counter, two compare/capture channels
`timescale 1ns/100ps
`default_nettype none
`include "tc_defines.vh"
module tc_core #(
   parameter PSC_DIV_W = 8
) (
   input wire clock,
   input wire reset_n,
   input wire counter_generic_clock,
   input wire count_event,
   input wire [1:0] capture_event,
   input wire low_power,
   input wire cfg_write,
   input wire cfg_enable,
   input wire [`TC_MODE_W-1:0] cfg_mode,
   input wire cfg_count_on_event,
   input wire [`TC_PSC_W-1:0] cfg_prescale,
   input wire cfg_dir_down,
   input wire cfg_wave_mode,
   input wire [1:0] cfg_capture_en,
   input wire [31:0] cfg_cc0,
   input wire [31:0] cfg_cc1,
   output wire cfg_busy,
   output reg [1:0] waveform_outputs,
   output reg [31:0] count_value,
   output reg [31:0] cc0_value,
   output reg [31:0] cc1_value,
   output reg update_event,
   output reg [1:0] channel_event,
   output reg irq,
   output reg wake_request,
   output reg dma_req_update,
   output reg [1:0] dma_req_channel
);
   // ------------------------------------------------------------
   // Reset release and counter clock sampling
   // ------------------------------------------------------------
   reg [1:0] rst_sync_q;
   wire rst_n;
   reg gclk_s1_q, gclk_s2_q, gclk_s3_q, gclk_lvl_q;
   wire gclk_tick;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Pair members share this one clock input, so they tick together
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gclk_s1_q <= 1'b0;
         gclk_s2_q <= 1'b0;
         gclk_s3_q <= 1'b0;
         gclk_lvl_q <= 1'b0;
      end else begin
         gclk_s1_q <= counter_generic_clock;
         gclk_s2_q <= gclk_s1_q;
         gclk_s3_q <= gclk_s2_q;
         if (gclk_s2_q == gclk_s3_q) begin
            gclk_lvl_q <= gclk_s3_q;
         end
      end
   end
   assign gclk_tick = (gclk_s2_q == gclk_s3_q) && gclk_s3_q && !gclk_lvl_q;

   // ------------------------------------------------------------
   // Configuration crossing
   // ------------------------------------------------------------
   reg [`TC_SYNC_CNT_W-1:0] sync_cnt_q;
   reg en_q, on_event_q, down_q, wave_q;
   reg [`TC_MODE_W-1:0] mode_q;
   reg [`TC_PSC_W-1:0] psc_q;
   reg [1:0] cap_en_q;
   reg [31:0] cc0_shadow_q, cc1_shadow_q;
   reg en_sh_q, on_event_sh_q, down_sh_q, wave_sh_q;
   reg [`TC_MODE_W-1:0] mode_sh_q;
   reg [`TC_PSC_W-1:0] psc_sh_q;
   reg [1:0] cap_en_sh_q;
   wire sync_done;
   wire [31:0] sync_load = `TC_SYNC_CYCLES;

   assign cfg_busy = (sync_cnt_q != {`TC_SYNC_CNT_W{1'b0}});
   assign sync_done = (sync_cnt_q == {{(`TC_SYNC_CNT_W-1){1'b0}}, 1'b1});

   // Writes during a transfer are refused; cfg_busy flags it
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_cnt_q <= {`TC_SYNC_CNT_W{1'b0}};
         en_sh_q <= 1'b0;
         on_event_sh_q <= 1'b0;
         down_sh_q <= 1'b0;
         wave_sh_q <= `TC_WAVE_FREQ;
         mode_sh_q <= `TC_MODE_16;
         psc_sh_q <= `TC_PSC_RESET;
         cap_en_sh_q <= 2'h0;
         cc0_shadow_q <= `TC_COUNT_RESET;
         cc1_shadow_q <= `TC_COUNT_RESET;
      end else if (cfg_write && !cfg_busy) begin
         sync_cnt_q <= sync_load[`TC_SYNC_CNT_W-1:0];
         en_sh_q <= cfg_enable;
         on_event_sh_q <= cfg_count_on_event;
         down_sh_q <= cfg_dir_down;
         wave_sh_q <= cfg_wave_mode;
         mode_sh_q <= cfg_mode;
         psc_sh_q <= cfg_prescale;
         cap_en_sh_q <= cfg_capture_en;
         cc0_shadow_q <= cfg_cc0;
         cc1_shadow_q <= cfg_cc1;
      end else if (cfg_busy) begin
         sync_cnt_q <= sync_cnt_q - {{(`TC_SYNC_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= 1'b0;
         on_event_q <= 1'b0;
         down_q <= 1'b0;
         wave_q <= `TC_WAVE_FREQ;
         mode_q <= `TC_MODE_16;
         psc_q <= `TC_PSC_RESET;
         cap_en_q <= 2'h0;
      end else if (sync_done) begin
         en_q <= en_sh_q;
         on_event_q <= on_event_sh_q;
         down_q <= down_sh_q;
         wave_q <= wave_sh_q;
         mode_q <= mode_sh_q;
         psc_q <= psc_sh_q;
         cap_en_q <= cap_en_sh_q;
      end
   end

   // ------------------------------------------------------------
   // Width helpers
   // ------------------------------------------------------------
   function [31:0] width_max;
      input [`TC_MODE_W-1:0] mode;
      begin
         case (mode)
            `TC_MODE_8: width_max = 32'h000000ff;
            `TC_MODE_32: width_max = 32'hffffffff;
            default: width_max = 32'h0000ffff;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Prescaler and count source
   // ------------------------------------------------------------
   wire psc_tick;
   wire step;
   wire [31:0] max_val, top_val, cc0_m, cc1_m;
   wire at_top, at_zero;

   tc_prescaler #(
      .DIV_W(PSC_DIV_W)
   ) u_psc (
      .clock(clock),
      .rst_n(rst_n),
      .clear(!en_q),
      .tick_in(gclk_tick),
      .sel(psc_q),
      .tick_out(psc_tick)
   );

   // Low power does not gate the count
   assign step = en_q && (on_event_q ? count_event : psc_tick);
   assign max_val = width_max(mode_q);
   assign cc0_m = cc0_shadow_q & max_val;
   assign cc1_m = cc1_shadow_q & max_val;
   assign top_val = (wave_q == `TC_WAVE_FREQ) ? cc0_m : max_val;
   assign at_top = (count_value == top_val);
   assign at_zero = (count_value == 32'h00000000);

   // ------------------------------------------------------------
   // Counter, channels and waveforms
   // ------------------------------------------------------------
   reg upd;
   reg [1:0] match;
   reg [1:0] capt;
   reg [31:0] count_d;

   always @* begin
      count_d = count_value;
      upd = 1'b0;
      if (step) begin
         if (down_q) begin
            if (at_zero) begin
               count_d = top_val;
               upd = 1'b1;
            end else begin
               count_d = count_value - 32'h00000001;
            end
         end else begin
            if (at_top) begin
               count_d = 32'h00000000;
               upd = 1'b1;
            end else begin
               count_d = (count_value + 32'h00000001) & max_val;
            end
         end
      end
      capt = cap_en_q & capture_event & {2{en_q}};
      match[0] = step && !cap_en_q[0] && (count_value == cc0_m);
      match[1] = step && !cap_en_q[1] && (count_value == cc1_m);
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_value <= `TC_COUNT_RESET;
         cc0_value <= `TC_COUNT_RESET;
         cc1_value <= `TC_COUNT_RESET;
         waveform_outputs <= 2'h0;
      end else begin
         count_value <= en_q ? count_d : `TC_COUNT_RESET;
         if (capt[0]) begin
            cc0_value <= count_value;
         end else if (!cap_en_q[0]) begin
            cc0_value <= cc0_m;
         end
         if (capt[1]) begin
            cc1_value <= count_value;
         end else if (!cap_en_q[1]) begin
            cc1_value <= cc1_m;
         end
         if (!en_q) begin
            waveform_outputs <= 2'h0;
         end else if (wave_q == `TC_WAVE_PWM) begin
            waveform_outputs[0] <= (count_d < cc0_m);
            waveform_outputs[1] <= (count_d < cc1_m);
         end else begin
            if (match[0]) begin
               waveform_outputs[0] <= !waveform_outputs[0];
            end
            if (match[1]) begin
               waveform_outputs[1] <= !waveform_outputs[1];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt, event, wake and DMA pulses
   // ------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         update_event <= 1'b0;
         channel_event <= 2'h0;
         irq <= 1'b0;
         wake_request <= 1'b0;
         dma_req_update <= 1'b0;
         dma_req_channel <= 2'h0;
      end else begin
         update_event <= upd;
         channel_event <= match | capt;
         irq <= upd || (|(match | capt));
         wake_request <= low_power && (upd || (|(match | capt)));
         dma_req_update <= upd;
         dma_req_channel <= match | capt;
      end
   end
endmodule // tc_core
`default_nettype wire

// ---- test/tc_core_monitor.sv ----
// Port checker of the timer/counter core
`timescale 1ns/100ps
`default_nettype none
module tc_core_monitor (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic low_power,
   input wire logic cfg_write,
   input wire logic cfg_busy,
   input wire logic [31:0] count_value,
   input wire logic update_event,
   input wire logic [1:0] channel_event,
   input wire logic irq,
   input wire logic wake_request,
   input wire logic dma_req_update,
   input wire logic [1:0] dma_req_channel
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   busy_hold_a: assert property (cfg_write && !cfg_busy |=>
      cfg_busy [*3] ##1 !cfg_busy) else $error("busy length");
   wake_irq_a: assert property (wake_request |-> irq)
      else $error("wake without irq");
   wake_sleep_a: assert property (wake_request |-> $past(low_power))
      else $error("wake while awake");
   irq_cause_a: assert property (irq |-> update_event ||
      channel_event != 2'h0) else $error("irq without cause");
   dma_update_a: assert property (dma_req_update == update_event)
      else $error("update dma");
   dma_chan_a: assert property (dma_req_channel == channel_event)
      else $error("channel dma");
   wrap_zero_a: assert property (update_event |->
      count_value == 32'h0 || $past(count_value) == 32'h0)
      else $error("update off zero");
   count_step_a: assert property ($changed(count_value) &&
      count_value != 32'h0 && !update_event |->
      count_value - $past(count_value) == 32'h1 ||
      $past(count_value) - count_value == 32'h1) else $error("count jump");
endmodule // tc_core_monitor
bind tc_core tc_core_monitor mon (.clock, .reset_n, .low_power, .cfg_write,
   .cfg_busy, .count_value, .update_event, .channel_event, .irq,
   .wake_request, .dma_req_update, .dma_req_channel);
`default_nettype wire

// ---- test/tc_far_end.sv ----
// Far-side model: counter clock pin and event network sources
`timescale 1ns/100ps
`default_nettype none
module tc_far_end (
   input wire logic clock,
   output logic counter_generic_clock = 1'b0,
   output logic count_event = 1'b0,
   output logic [1:0] capture_event = 2'h0
);
   // Back-to-back single-cycle event pulses
   task automatic events(input int n);
      repeat (n) @(negedge clock) count_event = 1'b1;
      @(negedge clock) count_event = 1'b0;
   endtask
   task automatic capture(input int ch);
      @(negedge clock) capture_event[ch] = 1'b1;
      @(negedge clock) capture_event = 2'h0;
   endtask
   // One pin clock for the pair; it stands low outside a burst
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clock) counter_generic_clock = 1'b1;
         repeat (4) @(negedge clock);
         counter_generic_clock = 1'b0;
         repeat (3) @(negedge clock);
      end
   endtask
endmodule // tc_far_end
`default_nettype wire

// ---- test/timer_counter_core_test.sv ----
// Self-checking testbench of the timer/counter core
`timescale 1ns/100ps
`default_nettype none
`include "tc_defines.vh"
module timer_counter_core_test;
   logic clock = 1'b0, reset_n = 1'b0, low_power = 1'b0, cfg_write = 1'b0;
   logic cfg_enable = 1'b0, cfg_count_on_event = 1'b0, cfg_dir_down = 1'b0;
   logic cfg_wave_mode = 1'b0;
   logic [1:0] cfg_mode = 2'h0, cfg_capture_en = 2'h0;
   logic [2:0] cfg_prescale = 3'h1;
   logic [31:0] cfg_cc0 = 32'h0, cfg_cc1 = 32'h0;
   wire counter_generic_clock, count_event, cfg_busy, update_event, irq;
   wire wake_request, dma_req_update;
   wire [1:0] capture_event, waveform_outputs, channel_event, dma_req_channel;
   wire [31:0] count_value, cc0_value, cc1_value;
   wire [10:0] flags = {waveform_outputs, update_event, channel_event, irq,
      wake_request, dma_req_update, dma_req_channel, cfg_busy};
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   tc_core uut (.clock, .reset_n, .counter_generic_clock, .count_event,
      .capture_event, .low_power, .cfg_write, .cfg_enable, .cfg_mode,
      .cfg_count_on_event, .cfg_prescale, .cfg_dir_down, .cfg_wave_mode,
      .cfg_capture_en, .cfg_cc0, .cfg_cc1, .cfg_busy, .waveform_outputs,
      .count_value, .cc0_value, .cc1_value, .update_event, .channel_event,
      .irq, .wake_request, .dma_req_update, .dma_req_channel);
   tc_far_end far (.clock, .counter_generic_clock, .count_event,
      .capture_event);
   always #5 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkf(input logic [10:0] e, input logic [10:0] m);
      samples_checked++;
      if ((flags & m) !== e) begin
         miscompares++;
         $display("ERROR %0t: flags %h expected %h", $time, flags, e);
      end
   endtask
   task automatic cfg(input logic en, input logic [1:0] md, input logic ev,
      input logic dn, input logic wv, input logic [1:0] cp,
      input logic [31:0] c0, input logic [31:0] c1, input logic [2:0] ps);
      @(negedge clock);
      {cfg_enable, cfg_mode, cfg_count_on_event} = {en, md, ev};
      {cfg_dir_down, cfg_wave_mode, cfg_capture_en} = {dn, wv, cp};
      {cfg_cc0, cfg_cc1, cfg_prescale} = {c0, c1, ps};
      cfg_write = 1'b1;
      @(negedge clock);
      cfg_write = 1'b0;
      repeat (3) begin
         chkf(11'h001, 11'h001);
         @(negedge clock);
      end
      chkf(11'h000, 11'h001);
   endtask
   task automatic off;
      cfg(1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 32'h0, 32'h0, 3'h0);
   endtask
   task automatic t_refuse;
      @(negedge clock);
      cfg_count_on_event = 1'b1;
      cfg_write = 1'b1;
      @(negedge clock);
      cfg_enable = 1'b1;
      repeat (2) @(negedge clock);
      cfg_write = 1'b0;
      far.events(2);
      chk(count_value, 32'h0);
   endtask
   task automatic t_up;
      cfg(1'b1, `TC_MODE_8, 1'b1, 1'b0, `TC_WAVE_FREQ, 2'h0, 32'h2, 32'h1,
         3'h0);
      far.events(2);
      chk(count_value, 32'h2);
      chkf(11'h4a4, 11'h7ff);
      far.events(1);
      chk(count_value, 32'h0);
      chkf(11'h76a, 11'h7ff);
      off;
   endtask
   task automatic t_down;
      logic [1:0] md [3] = '{`TC_MODE_8, `TC_MODE_16, `TC_MODE_32};
      logic [31:0] mx [3] = '{32'hff, 32'hffff, 32'hffffffff};
      for (int i = 0; i < 3; i++) begin
         cfg(1'b1, md[i], 1'b1, 1'b1, `TC_WAVE_PWM, 2'h0, 32'h0, 32'h0,
            3'h0);
         far.events(1);
         chk(count_value, mx[i]);
         chkf(11'h1ee, 11'h1ff);
         far.events(1);
         chk(count_value, mx[i] - 32'h1);
         off;
      end
   endtask
   task automatic t_cap;
      low_power = 1'b1;
      cfg(1'b1, `TC_MODE_16, 1'b1, 1'b0, `TC_WAVE_FREQ, 2'h2, 32'h64,
         32'h0, 3'h0);
      far.events(3);
      far.capture(1);
      chk(cc1_value, 32'h3);
      chk(cc0_value, 32'h64);
      chk(count_value, 32'h3);
      chkf(11'h0b4, 11'h1ff);
      low_power = 1'b0;
      off;
   endtask
   task automatic t_psc;
      logic [2:0] ps [3] = '{3'h0, 3'h1, 3'h2};
      logic [31:0] cn [3] = '{32'h4, 32'h2, 32'h1};
      logic [10:0] wv [3] = '{11'h000, 11'h400, 11'h600};
      for (int i = 0; i < 3; i++) begin
         cfg(1'b1, `TC_MODE_16, 1'b0, 1'b0, `TC_WAVE_PWM, 2'h0, 32'h2,
            32'h3, ps[i]);
         far.ticks(4);
         repeat (6) @(negedge clock);
         chk(count_value, cn[i]);
         chkf(wv[i], 11'h7ff);
         off;
      end
   endtask
   task automatic finish_test;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         finish_test;
      end
   end
   initial begin
      repeat (5) @(negedge clock);
      reset_n = 1'b1;
      repeat (3) @(negedge clock);
      chkf(11'h000, 11'h7ff);
      chk(count_value, 32'h0);
      t_refuse;
      t_up;
      t_down;
      t_cap;
      t_psc;
      finish_test;
   end
endmodule // timer_counter_core_test
`default_nettype wire
